// *** core/sfre_pkg.sv ***
// Shared constants, types and decode functions of the fast read engine
package sfre_pkg;

  // ************************************************************
  // Protocol modes and transaction phases
  // ************************************************************
  typedef enum logic [1:0] {SFRE_SPI, SFRE_DUAL, SFRE_QUAD} sfre_proto_t;

  typedef enum logic [2:0] {
    SFRE_PH_OPC,
    SFRE_PH_ADDR,
    SFRE_PH_MODE,
    SFRE_PH_DUMMY,
    SFRE_PH_DATA,
    SFRE_PH_IGNORE
  } sfre_phase_t;

  // ************************************************************
  // Opcodes, mode byte patterns, field widths, timing
  // ************************************************************
  localparam logic [7:0] SFRE_OP_FAST = 8'h0b;
  localparam logic [7:0] SFRE_OP_DDR = 8'h0d;
  localparam logic [7:0] SFRE_OP_DOUT = 8'h3b;
  localparam logic [7:0] SFRE_OP_DIO = 8'hbb;
  localparam logic [7:0] SFRE_MODE_DDR = 8'ha5;
  localparam logic [3:0] SFRE_MODE_HI = 4'ha;
  localparam int SFRE_ADDR_W = 19;
  localparam logic [4:0] SFRE_OPC_BITS = 5'h08;
  localparam logic [4:0] SFRE_ADDR_BITS = 5'h18;
  localparam logic [4:0] SFRE_MODE_BITS = 5'h08;
  localparam logic [3:0] SFRE_BYTE_BITS = 4'h8;
  // Host link clock half period in clk cycles, less one
  localparam logic [2:0] SFRE_HALF_M1 = 3'h3;

  // ************************************************************
  // Decode functions used by both ends
  // ************************************************************
  function automatic logic [2:0] sfre_lanes(input logic [7:0] cmd, input sfre_proto_t proto,
                                            input sfre_phase_t ph);
    logic [2:0] pw;
    pw = (proto == SFRE_QUAD) ? 3'h4 : (proto == SFRE_DUAL) ? 3'h2 : 3'h1;
    if (ph == SFRE_PH_OPC || cmd == SFRE_OP_FAST) return pw;
    if (cmd == SFRE_OP_DDR) return 3'h4;
    if (cmd == SFRE_OP_DIO || ph == SFRE_PH_DATA) return 3'h2;
    return 3'h1;
  endfunction : sfre_lanes

  function automatic logic sfre_ddr(input logic [7:0] cmd, input sfre_phase_t ph);
    return (cmd == SFRE_OP_DDR) && (ph != SFRE_PH_OPC);
  endfunction : sfre_ddr

  function automatic logic [3:0] sfre_step(input logic [2:0] w, input logic ddr);
    return ddr ? {w, 1'b0} : {1'b0, w};
  endfunction : sfre_step

  function automatic logic [4:0] sfre_plen(input sfre_phase_t ph);
    return (ph == SFRE_PH_OPC) ? SFRE_OPC_BITS : (ph == SFRE_PH_ADDR) ? SFRE_ADDR_BITS :
           (ph == SFRE_PH_MODE) ? SFRE_MODE_BITS : 5'h00;
  endfunction : sfre_plen

  function automatic logic sfre_cmd_ok(input logic [7:0] cmd, input sfre_proto_t proto);
    return (cmd == SFRE_OP_FAST) || (cmd == SFRE_OP_DDR && proto == SFRE_QUAD) ||
           ((cmd == SFRE_OP_DOUT || cmd == SFRE_OP_DIO) && proto == SFRE_SPI);
  endfunction : sfre_cmd_ok

  function automatic logic sfre_cont_match(input logic [7:0] cmd, input logic [7:0] m);
    return (cmd == SFRE_OP_DDR) ? (m == SFRE_MODE_DDR) : (m[7:4] == SFRE_MODE_HI);
  endfunction : sfre_cont_match

  // Right-aligned bits of one lane group; single lane is lane one when hi is set
  function automatic logic [3:0] sfre_pick(input logic [3:0] v, input logic [2:0] w,
                                           input logic hi);
    if (w == 3'h4) return v;
    if (w == 3'h2) return {2'b00, v[1:0]};
    return {3'b000, hi ? v[1] : v[0]};
  endfunction : sfre_pick

endpackage : sfre_pkg

// *** core/sfre_if.sv ***
// Link between host controller and memory device of the fast read engine
`timescale 1ns/1ps
`default_nettype none
interface sfre_if;
  logic sck;
  logic cs_n;
  logic [3:0] host_o;
  logic [3:0] host_oe;
  logic [3:0] dev_o;
  logic [3:0] dev_oe;
  logic [3:0] io;

  // Undriven lanes read high, as with a pull-up
  assign io = (dev_o & dev_oe) | (host_o & host_oe) | ~(dev_oe | host_oe);

  modport dev (input sck, input cs_n, input io, output dev_o, output dev_oe);
  modport host (output sck, output cs_n, output host_o, output host_oe, input io);
endinterface : sfre_if
`default_nettype wire

// *** core/sfre_dev.sv ***
// Device end: fast read command engine clocked by the link clock
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Overview of operation
// - Opcode 0Bh plus address, any lane mode
// - Address steps by one after each byte
// - Address wraps from top to zero
// - Mode byte 1010xxxx enables opcode skipping
// - Other mode byte leaves opcode skipping
// - Latency code sets dummy cycle count
// - Opcode 0Dh quad only, both edges after the opcode
// - Double-edge read skips opcode only on A5h
// - Host uses clock mode 0 for 0Dh
// - Host holds select low through dummies
// - Opcode 3Bh header serial on lane zero
// - Lanes turn around at last dummy fall, or last mode fall if no dummies
// - Two-lane output, bit 7 on lane one
// - Opcode BBh address two bits per clock
// - Two-lane data return, bit 7 first
// - Only nineteen address bits are decoded
// ************************************************************

module sfre_dev
  import sfre_pkg::*;
(
  sfre_if.dev lnk,
  input wire logic nrst,
  input wire sfre_proto_t proto,
  input wire logic [3:0] lat_code,
  input wire logic [7:0] mem_data,
  output logic [18:0] mem_addr,
  output logic cont_mode
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic txn_rst_n;
  logic [3:0] rise_q;
  sfre_phase_t st_q;
  sfre_phase_t st_d;
  sfre_phase_t ph;
  logic first_q;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] cnt_sum;
  logic [23:0] sh_q;
  logic [23:0] sh_d;
  logic [7:0] cmd_q;
  logic [7:0] act_cmd;
  logic [18:0] addr_q;
  logic [7:0] tx_q;
  logic [3:0] tx_cnt_q;
  logic cont_q;
  logic [7:0] cont_cmd_q;
  logic [2:0] w;
  logic ddr;
  logic [3:0] n;
  logic [7:0] nb;
  logic ph_done;
  logic lat_zero;
  logic opc_ok;
  logic mode_hit;
  logic enter_data;
  logic in_data;
  logic tx_load;
  logic [2:0] dw;
  logic dddr;

  // ************************************************************
  // Transaction reset
  // ************************************************************
  // Select high clears all per-transaction state at once, since the
  // link clock stands still between frames
  assign txn_rst_n = nrst & ~lnk.cs_n;

  // Rising-edge sample; the falling edge consumes it, which lets one
  // process serve both single and double edge phases
  always_ff @(posedge lnk.sck or negedge txn_rst_n) begin
    if (!txn_rst_n) begin
      rise_q <= 4'h0;
    end else begin
      rise_q <= lnk.io;
    end
  end

  // ************************************************************
  // Phase decode
  // ************************************************************
  // The first cycle after select falls starts at the address when
  // opcode skipping is armed
  assign ph = (first_q && cont_q) ? SFRE_PH_ADDR : st_q;
  assign act_cmd = first_q ? cont_cmd_q : cmd_q;
  assign w = sfre_lanes(act_cmd, proto, ph);
  assign ddr = sfre_ddr(act_cmd, ph);
  assign n = sfre_step(w, ddr);
  // Double edge: rising nibble first, falling nibble from the pins now
  assign nb = ddr ? {rise_q, lnk.io} : {4'h0, sfre_pick(rise_q, w, 1'b0)};
  assign sh_d = (sh_q << n) | {16'h0000, nb};
  assign cnt_sum = cnt_q + {1'b0, n};
  assign lat_zero = (lat_code == 4'h0);
  assign ph_done = (ph == SFRE_PH_DUMMY) ?
                   ((cnt_q + 5'h01) >= {1'b0, lat_code}) :
                   (cnt_sum >= sfre_plen(ph));
  assign opc_ok = sfre_cmd_ok(sh_d[7:0], proto);
  assign mode_hit = sfre_cont_match(act_cmd, sh_d[7:0]);

  always_comb begin
    st_d = ph;
    unique case (ph)
      SFRE_PH_OPC: begin
        if (ph_done) begin
          st_d = opc_ok ? SFRE_PH_ADDR : SFRE_PH_IGNORE;
        end
      end
      SFRE_PH_ADDR: begin
        if (ph_done) begin
          st_d = SFRE_PH_MODE;
        end
      end
      SFRE_PH_MODE: begin
        if (ph_done) begin
          st_d = lat_zero ? SFRE_PH_DATA : SFRE_PH_DUMMY;
        end
      end
      SFRE_PH_DUMMY: begin
        if (ph_done) begin
          st_d = SFRE_PH_DATA;
        end
      end
      SFRE_PH_DATA, SFRE_PH_IGNORE: begin
        st_d = ph;
      end
      default: begin
        st_d = SFRE_PH_IGNORE;
      end
    endcase
  end

  assign cnt_d = (st_d != ph) ? 5'h00 : (ph == SFRE_PH_DUMMY) ? (cnt_q + 5'h01) : cnt_sum;

  // ************************************************************
  // Data stream control
  // ************************************************************
  // Lanes turn around on the falling edge that ends the last dummy cycle, or the mode byte when the latency code is zero
  assign enter_data = ph_done &&
                      ((ph == SFRE_PH_MODE && lat_zero) || ph == SFRE_PH_DUMMY);
  assign in_data = (st_q == SFRE_PH_DATA);
  assign tx_load = enter_data || (in_data && (tx_cnt_q <= n));
  assign dw = sfre_lanes(cmd_q, proto, SFRE_PH_DATA);
  assign dddr = sfre_ddr(cmd_q, SFRE_PH_DATA);

  // ************************************************************
  // Falling-edge transaction engine
  // ************************************************************
  always_ff @(negedge lnk.sck or negedge txn_rst_n) begin
    if (!txn_rst_n) begin
      st_q <= SFRE_PH_OPC;
      first_q <= 1'b1;
      cnt_q <= 5'h00;
      sh_q <= 24'h000000;
      cmd_q <= 8'h00;
      addr_q <= 19'h00000;
      tx_q <= 8'h00;
      tx_cnt_q <= 4'h0;
    end else begin
      st_q <= st_d;
      first_q <= 1'b0;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      if (first_q) begin
        cmd_q <= act_cmd;
      end
      if (ph == SFRE_PH_OPC && ph_done) begin
        cmd_q <= sh_d[7:0];
      end
      if (ph == SFRE_PH_ADDR && ph_done) begin
        addr_q <= sh_d[SFRE_ADDR_W-1:0];
      end else if (tx_load) begin
        // Natural 19-bit rollover takes the top location back to zero
        addr_q <= addr_q + 19'h00001;
      end
      if (tx_load) begin
        tx_q <= mem_data;
        tx_cnt_q <= SFRE_BYTE_BITS;
      end else if (in_data) begin
        tx_q <= tx_q << n;
        tx_cnt_q <= tx_cnt_q - n;
      end
    end
  end

  // Opcode skipping survives select going high; only power-on reset or a non-matching mode byte clears it
  always_ff @(negedge lnk.sck or negedge nrst) begin
    if (!nrst) begin
      cont_q <= 1'b0;
      cont_cmd_q <= 8'h00;
    end else if (!lnk.cs_n && ph == SFRE_PH_MODE && ph_done) begin
      cont_q <= mode_hit;
      cont_cmd_q <= act_cmd;
    end
  end

  // ************************************************************
  // Lane drivers
  // ************************************************************
  // Double edge: high nibble while the clock is low, low nibble while high
  assign lnk.dev_o = dddr ? (lnk.sck ? tx_q[3:0] : tx_q[7:4]) :
                     (dw == 3'h4) ? tx_q[7:4] :
                     (dw == 3'h2) ? {2'b00, tx_q[7:6]} :
                     {2'b00, tx_q[7], 1'b0};
  assign lnk.dev_oe = !in_data ? 4'h0 :
                      (dw == 3'h4) ? 4'hf : (dw == 3'h2) ? 4'h3 : 4'h2;
  assign mem_addr = addr_q;
  assign cont_mode = cont_q;

endmodule : sfre_dev
`default_nettype wire

// *** core/sfre_host.sv ***
// Host end: controller issuing fast read transactions over the link
`timescale 1ns/1ps
`default_nettype none
module sfre_host
  import sfre_pkg::*;
(
  sfre_if.host lnk,
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [7:0] cmd,
  input wire logic [18:0] addr,
  input wire logic [7:0] mode_byte,
  input wire sfre_proto_t proto,
  input wire logic [3:0] lat_code,
  input wire logic [15:0] nbytes,
  output logic busy,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic cont_mode
);

  typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_GAP} sfre_hst_t;

  // ************************************************************
  // Declarations
  // ************************************************************
  sfre_hst_t hs_q;
  logic [2:0] div_q;
  logic sck_q;
  logic cs_n_q;
  sfre_phase_t ph_q;
  sfre_phase_t ph_d;
  logic [4:0] cnt_q;
  logic [39:0] hdr_q;
  logic [7:0] cmd_q;
  logic cont_q;
  logic [7:0] cont_cmd_q;
  logic [3:0] io_s1_q;
  logic [3:0] io_s2_q;
  logic [7:0] rx_q;
  logic [3:0] rx_cnt_q;
  logic [15:0] byte_cnt_q;
  logic end_q;
  logic rd_valid_q;
  logic [7:0] rd_data_q;
  logic edge_t;
  logic rise_t;
  logic fall_t;
  logic skip;
  logic [2:0] w;
  logic ddr;
  logic [3:0] n;
  logic [2:0] dw;
  logic dddr;
  logic ph_done;
  logic hdr_phase;
  logic samp;
  logic [7:0] rx_nxt;
  logic [3:0] rx_sum;
  logic byte_done;
  logic [3:0] host_o_d;
  logic [3:0] host_o_q;
  logic ddr_hold_q;

  // ************************************************************
  // Decode
  // ************************************************************
  // Clock idles low: mode 0, the only mode the double-edge read allows
  assign edge_t = (hs_q == HS_RUN) && (div_q == SFRE_HALF_M1);
  assign rise_t = edge_t && !sck_q;
  assign fall_t = edge_t && sck_q;
  assign skip = cont_q && (cmd == cont_cmd_q);
  assign w = sfre_lanes(cmd_q, proto, ph_q);
  assign ddr = sfre_ddr(cmd_q, ph_q);
  assign n = sfre_step(w, ddr);
  assign dw = sfre_lanes(cmd_q, proto, SFRE_PH_DATA);
  assign dddr = sfre_ddr(cmd_q, SFRE_PH_DATA);
  assign ph_done = (ph_q == SFRE_PH_DUMMY) ? ((cnt_q + 5'h01) >= {1'b0, lat_code}) :
                   ((cnt_q + {1'b0, n}) >= sfre_plen(ph_q));
  assign ph_d = !ph_done ? ph_q :
                (ph_q == SFRE_PH_OPC) ? SFRE_PH_ADDR :
                (ph_q == SFRE_PH_ADDR) ? SFRE_PH_MODE :
                (ph_q == SFRE_PH_MODE && lat_code != 4'h0) ? SFRE_PH_DUMMY : SFRE_PH_DATA;
  assign hdr_phase = (hs_q == HS_RUN) && (ph_q == SFRE_PH_OPC || ph_q == SFRE_PH_ADDR ||
                                          ph_q == SFRE_PH_MODE);
  // Data is sampled just before each rising edge, and each falling edge for double edge, from the synchronised pins
  assign samp = (hs_q == HS_RUN) && (ph_q == SFRE_PH_DATA) && !end_q &&
                (rise_t || (fall_t && dddr));
  assign rx_nxt = (rx_q << dw) | {4'h0, sfre_pick(io_s2_q, dw, 1'b1)};
  assign rx_sum = rx_cnt_q + {1'b0, dw};
  assign byte_done = samp && (rx_sum >= SFRE_BYTE_BITS);

  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else begin
      io_s1_q <= lnk.io;
      io_s2_q <= io_s1_q;
    end
  end

  // ************************************************************
  // Lane register
  // ************************************************************
  // Lanes move one clk after each link edge, so the device never samples
  // them in the time step in which they change
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_o_q <= 4'h0;
      ddr_hold_q <= 1'b0;
    end else begin
      host_o_q <= host_o_d;
      ddr_hold_q <= hdr_phase && ddr;
    end
  end

  // ************************************************************
  // Transaction sequencer
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hs_q <= HS_IDLE;
      div_q <= 3'h0;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      ph_q <= SFRE_PH_OPC;
      cnt_q <= 5'h00;
      hdr_q <= 40'h0000000000;
      cmd_q <= 8'h00;
      cont_q <= 1'b0;
      cont_cmd_q <= 8'h00;
      rx_q <= 8'h00;
      rx_cnt_q <= 4'h0;
      byte_cnt_q <= 16'h0000;
      end_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      rd_valid_q <= 1'b0;
      unique case (hs_q)
        HS_IDLE: begin
          div_q <= 3'h0;
          if (start) begin
            hs_q <= HS_RUN;
            cs_n_q <= 1'b0;
            cmd_q <= cmd;
            cnt_q <= 5'h00;
            rx_cnt_q <= 4'h0;
            byte_cnt_q <= 16'h0000;
            end_q <= 1'b0;
            // Mirror of the device: assumes the header is sent in full
            cont_q <= sfre_cmd_ok(cmd, proto) && sfre_cont_match(cmd, mode_byte);
            cont_cmd_q <= cmd;
            if (skip) begin
              ph_q <= SFRE_PH_ADDR;
              hdr_q <= {5'h00, addr, mode_byte, 8'h00};
            end else begin
              ph_q <= SFRE_PH_OPC;
              hdr_q <= {cmd, 5'h00, addr, mode_byte};
            end
          end
        end
        HS_RUN: begin
          div_q <= edge_t ? 3'h0 : div_q + 3'h1;
          if (edge_t) begin
            sck_q <= ~sck_q;
          end
          // Select rises only after a falling edge, never inside dummies
          if (fall_t && end_q) begin
            cs_n_q <= 1'b1;
            hs_q <= HS_GAP;
          end
          if (fall_t && ph_q != SFRE_PH_DATA) begin
            ph_q <= ph_d;
            cnt_q <= (ph_d != ph_q) ? 5'h00 :
                     (ph_q == SFRE_PH_DUMMY) ? (cnt_q + 5'h01) : (cnt_q + {1'b0, n});
            hdr_q <= hdr_q << n;
          end
          if (samp) begin
            rx_q <= rx_nxt;
            rx_cnt_q <= byte_done ? 4'h0 : rx_sum;
          end
          if (byte_done) begin
            rd_valid_q <= 1'b1;
            rd_data_q <= rx_nxt;
            byte_cnt_q <= byte_cnt_q + 16'h0001;
            if ((byte_cnt_q + 16'h0001) >= nbytes) begin
              end_q <= 1'b1;
            end
          end
        end
        HS_GAP: begin
          div_q <= div_q + 3'h1;
          if (div_q == SFRE_HALF_M1) begin
            hs_q <= HS_IDLE;
          end
        end
        default: begin
          hs_q <= HS_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Double edge: second nibble is presented while the clock is high
  assign host_o_d = ddr ? (sck_q ? hdr_q[35:32] : hdr_q[39:36]) :
                    (w == 3'h4) ? hdr_q[39:36] :
                    (w == 3'h2) ? {2'b00, hdr_q[39:38]} : {3'b000, hdr_q[39]};
  assign lnk.host_o = host_o_q;
  // Double edge: the last header nibble is taken at a fall, so the lanes
  // stay driven one clk longer; such frames need one dummy cycle at least
  assign lnk.host_oe = ddr_hold_q ? 4'hf : !hdr_phase ? 4'h0 :
                       (w == 3'h4) ? 4'hf : (w == 3'h2) ? 4'h3 : 4'h1;
  assign lnk.sck = sck_q;
  assign lnk.cs_n = cs_n_q;
  assign busy = (hs_q != HS_IDLE);
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign cont_mode = cont_q;

endmodule : sfre_host
`default_nettype wire

// *** bench/sfre_monitor.sv ***
// Concurrent checks on the link between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module sfre_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_o,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] io
);
  // ************************************************************
  // Link checks, sampled in the host clock domain
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  cs_release_a: assert property (cs_n |-> dev_oe == 4'h0)
    else $error("device drives while deselected");
  no_clash_a: assert property ((dev_oe & host_oe) == 4'h0)
    else $error("both ends drive one lane");
  turn_edge_a: assert property ($rose(|dev_oe) |-> $fell(sck))
    else $error("lanes turned away from a falling edge");
  lane_set_a: assert property (dev_oe != 4'h0 |-> dev_oe inside {4'h2, 4'h3, 4'hf})
    else $error("device drives an odd lane group");
  pair_hold_a: assert property (dev_oe == 4'h3 && $past(dev_oe) == 4'h3 && !$fell(sck)
    |-> $stable(io[1:0])) else $error("two-lane data moved off a falling edge");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("link clock not low while idle");
  sck_high_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("link clock high phase wrong");
  header_quiet_a: assert property ($fell(cs_n) |-> (dev_oe == 4'h0) [*8])
    else $error("device drove during the header");

  cover property ($rose(dev_oe == 4'h3));
  cover property ($rose(dev_oe == 4'hf));
  cover property ($rose(dev_oe == 4'h2));
  cover property (dev_oe == 4'hf && sck && $changed(dev_o));
endmodule : sfre_monitor
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench joining both ends of the fast read engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sfre_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic [7:0] cmd = 8'h0b;
  logic [18:0] addr = 19'h0;
  logic [7:0] mode_byte = 8'h00;
  sfre_proto_t proto = SFRE_SPI;
  logic [3:0] lat_code = 4'h0;
  logic [15:0] nbytes = 16'h0001;
  wire logic busy;
  wire logic rd_valid;
  wire logic h_cont;
  wire logic d_cont;
  wire logic [7:0] rd_data;
  wire logic [7:0] mem_data;
  wire logic [18:0] mem_addr;
  int mismatches = 0;
  int compares = 0;
  int seed = 90340;
  int lat_clk = 0;
  int l1;
  int r;
  logic [7:0] m;
  logic hc = 1'b0;
  logic dc = 1'b0;
  logic [7:0] cl [4] = '{8'h0b, 8'h3b, 8'hbb, 8'h0d};
  sfre_proto_t pl [4] = '{SFRE_SPI, SFRE_SPI, SFRE_SPI, SFRE_QUAD};
  logic [7:0] rc [6] = '{8'h0b, 8'h0b, 8'h0b, 8'h0d, 8'h3b, 8'hbb};
  sfre_proto_t rp [6] = '{SFRE_SPI, SFRE_DUAL, SFRE_QUAD, SFRE_QUAD, SFRE_SPI, SFRE_SPI};

  always #5 clk = ~clk;

  sfre_if lnk ();
  sfre_host u_sfre_host (.lnk(lnk.host), .clk(clk), .nrst(nrst), .start(start), .cmd(cmd),
    .addr(addr), .mode_byte(mode_byte), .proto(proto), .lat_code(lat_code), .nbytes(nbytes),
    .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data), .cont_mode(h_cont));
  sfre_dev u_sfre_dev (.lnk(lnk.dev), .nrst(nrst), .proto(proto), .lat_code(lat_code),
    .mem_data(mem_data), .mem_addr(mem_addr), .cont_mode(d_cont));
  sfre_monitor u_sfre_monitor (.clk(clk), .nrst(nrst), .sck(lnk.sck), .cs_n(lnk.cs_n),
    .host_oe(lnk.host_oe), .dev_o(lnk.dev_o), .dev_oe(lnk.dev_oe), .io(lnk.io));

  // Memory content mixes upper and lower address bits so wrap faults show
  function automatic logic [7:0] memf(input logic [18:0] a);
    return a[7:0] ^ {a[18:16], a[12:8]};
  endfunction : memf

  assign mem_data = memf(mem_addr);

  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // ************************************************************
  // One transaction, checked byte by byte against the model
  // ************************************************************
  task automatic run(input logic [7:0] c, input sfre_proto_t p, input logic [18:0] a,
                     input logic [7:0] mb, input logic [3:0] l, input int n, input logic ok);
    int got;
    int t;
    logic [18:0] ea;
    logic mt;
    got = 0;
    t = 0;
    ea = a;
    @(posedge clk);
    #1;
    cmd = c;
    proto = p;
    addr = a;
    mode_byte = mb;
    lat_code = l;
    nbytes = 16'(n);
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    while (busy === 1'b1 && t < 20000) begin
      @(posedge clk);
      #1;
      t++;
      if (rd_valid === 1'b1) begin
        if (got == 0)
          lat_clk = t;
        check("rd_data", ok ? memf(ea) : 8'hff, rd_data);
        ea = ea + 19'h1;
        got++;
      end
    end
    check("byte count", n, got);
    mt = (c == 8'h0d) ? (mb == 8'ha5) : (mb[7:4] == 4'ha);
    hc = mt;
    if (ok)
      dc = mt;
    check("host cont", hc, h_cont);
    check("dev cont", dc, d_cont);
  endtask : run

  initial begin
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    for (int i = 0; i < 4; i++) begin
      m = (cl[i] == 8'h0d) ? 8'ha5 : 8'ha3;
      run(cl[i], pl[i], 19'h00100, m, 4'h1, 2, 1'b1);
      l1 = lat_clk;
      run(cl[i], pl[i], 19'h00100, ~m, 4'h1, 2, 1'b1);
      check("opcode skip", l1 - ((cl[i] == 8'h0d) ? 16 : 64), lat_clk);
      run(cl[i], pl[i], 19'h00100, (cl[i] == 8'h0d) ? 8'ha7 : ~m, 4'h1, 2, 1'b1);
      check("opcode back", l1, lat_clk);
    end
    $display("test opcode skip done");
    run(8'h3b, SFRE_SPI, 19'h2a5a5, 8'h00, 4'h0, 3, 1'b1);
    l1 = lat_clk;
    run(8'h3b, SFRE_SPI, 19'h2a5a5, 8'h00, 4'hf, 3, 1'b1);
    check("latency", l1 + 120, lat_clk);
    $display("test latency done");
    run(8'h0b, SFRE_DUAL, 19'h7fffe, 8'h00, 4'h3, 4, 1'b1);
    run(8'hbb, SFRE_SPI, 19'h7ffff, 8'h00, 4'h2, 2, 1'b1);
    // Double-edge frames keep one dummy cycle for the lane turnaround
    run(8'h0d, SFRE_QUAD, 19'h7ffff, 8'h00, 4'h1, 3, 1'b1);
    $display("test wrap done");
    // Refused frames: the device stays off the lanes, so the host reads pull-ups
    run(8'h0d, SFRE_SPI, 19'h00010, 8'h00, 4'h1, 2, 1'b0);
    run(8'h3b, SFRE_QUAD, 19'h00010, 8'h00, 4'h1, 2, 1'b0);
    $display("test refusal done");
    for (int i = 0; i < 12; i++) begin
      r = xs();
      run(rc[i % 6], rp[i % 6], r[18:0], r[26:19],
          r[30:27] | 4'(rc[i % 6] == 8'h0d), 1 + i % 4, 1'b1);
      if (hc)
        run(rc[i % 6], rp[i % 6], r[18:0] ^ 19'h55, 8'h00, 4'h2, 2, 1'b1);
    end
    $display("test random done");
    print_verdict();
  end

  initial begin
    #900000;
    mismatches++;
    $display("BAD watchdog expected done seen hang");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
